// *** eef_top.sv ***
// ethernet event flags: status byte, event enables and flags, phy enables and flags, int_n
// assumes event strobes and levels come from logic on clk_sys; host uses the command port
//
// What this block does
// - status bit 7 reads 1 while any enabled event flag is set
// - status bit 6 sets on buffer overrun or underrun, host clears
// - status bit 4 sets on collision after 64 bytes, host clears
// - status bit 2 reads 1 while receive logic takes a packet
// - status bit 1 sets on transmit abort, stays until host clears
// - status bit 0 reads 1 once the oscillator start-up timer expired
// - reserved and unused positions always read zero
// - global enable low holds the interrupt output high
// - enable register holds per-source enables; logic keeps bit 2 zero whatever the host writes
// - packet pending flag is read-only, 1 while packets remain
// - copy done flag sets on copy or checksum completion, host clears
// - link change flag is read-only, cleared by reading phy flags
// - transmit done flag sets when a transmit request ends, host clears
// - transmit error flag sets on transmit error, host clears
// - receive error flag sets when a packet is dropped
// - phy enable has writable bits 4 and 1, rest read zero
// - phy link flag sets on link change, cleared by reading
// - phy global flag sets on enabled phy event, cleared by reading
// - four flags host-clearable; packet pending and link change ignore writes
// - interrupt low only with flag, its enable and global enable
// - interrupt stays low until causing flags cleared or masked
// - flags other than link change set regardless of enables
// - link change flag mirrors phy global flag when both phy enables set
`timescale 1ns/1ps
module eef_top
    import eef_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire eef_cmd_t    cmd,
    input  wire eef_events_t events,
    output eef_rsp_t         rsp,
    output logic             int_n
);

    // ==========
    // command decode
    // ==========
    logic is_status;
    logic is_enable;
    logic is_flags;
    logic is_phy_enable;
    logic is_phy_flags;
    logic is_mapped;
    logic do_write;
    logic do_set;
    logic do_clear;
    logic do_read;

    assign is_status     = cmd.req & (cmd.addr == EEF_IDX_STATUS);
    assign is_enable     = cmd.req & (cmd.addr == EEF_IDX_ENABLE);
    assign is_flags      = cmd.req & (cmd.addr == EEF_IDX_FLAGS);
    assign is_phy_enable = cmd.req & (cmd.addr == EEF_IDX_PHY_ENABLE);
    assign is_phy_flags  = cmd.req & (cmd.addr == EEF_IDX_PHY_FLAGS);
    assign is_mapped     = is_status | is_enable | is_flags | is_phy_enable | is_phy_flags;
    assign do_write      = cmd.req & (cmd.op == EEF_OP_WRITE);
    assign do_set        = cmd.req & (cmd.op == EEF_OP_SET);
    assign do_clear      = cmd.req & (cmd.op == EEF_OP_CLEAR);
    assign do_read       = cmd.req & (cmd.op == EEF_OP_READ);

    // ==========
    // event enable register
    // ==========
    logic [7:0] enable_ff;
    logic [7:0] nxt_enable;

    always_comb begin
        nxt_enable = enable_ff;
        if (is_enable & do_write) begin
            nxt_enable = cmd.wdata[7:0];
        end else if (is_enable & do_set) begin
            nxt_enable = enable_ff | cmd.wdata[7:0];
        end else if (is_enable & do_clear) begin
            nxt_enable = enable_ff & ~cmd.wdata[7:0];
        end
        // reserved bit 2 held at zero whatever the host sends
        nxt_enable = nxt_enable & EEF_ENABLE_WR_MASK;
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            enable_ff <= EEF_ENABLE_RESET;
        end else begin
            enable_ff <= nxt_enable;
        end
    end

    // ==========
    // phy enable register
    // ==========
    logic [15:0] phy_enable_ff;
    logic [15:0] nxt_phy_enable;
    logic [15:0] phy_enable_mask;

    assign phy_enable_mask = (16'h_0001 << EEF_PHY_LINK_CHANGE) | (16'h_0001 << EEF_PHY_GLOBAL_EN);

    always_comb begin
        nxt_phy_enable = phy_enable_ff;
        if (is_phy_enable & do_write) begin
            nxt_phy_enable = cmd.wdata;
        end else if (is_phy_enable & do_set) begin
            nxt_phy_enable = phy_enable_ff | cmd.wdata;
        end else if (is_phy_enable & do_clear) begin
            nxt_phy_enable = phy_enable_ff & ~cmd.wdata;
        end
        nxt_phy_enable = nxt_phy_enable & phy_enable_mask;
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            phy_enable_ff <= EEF_PHY_ENABLE_RESET;
        end else begin
            phy_enable_ff <= nxt_phy_enable;
        end
    end

    logic phy_both_enabled;

    assign phy_both_enabled = phy_enable_ff[EEF_PHY_LINK_CHANGE] & phy_enable_ff[EEF_PHY_GLOBAL_EN];

    // ==========
    // host clear strobes for clearable bits
    // ==========
    // a write clears where the written bit is 0; a bit clear clears where it is 1
    logic [7:0] status_clr_mask;
    logic [7:0] flags_clr_mask;

    always_comb begin
        status_clr_mask = 8'h_00;
        flags_clr_mask  = 8'h_00;
        if (is_status & do_write) begin
            status_clr_mask = ~cmd.wdata[7:0];
        end else if (is_status & do_clear) begin
            status_clr_mask = cmd.wdata[7:0];
        end
        if (is_flags & do_write) begin
            flags_clr_mask = ~cmd.wdata[7:0];
        end else if (is_flags & do_clear) begin
            flags_clr_mask = cmd.wdata[7:0];
        end
    end

    // ==========
    // status clearable bits: buffer error, late collision, tx aborted
    // ==========
    logic [2:0] status_set;
    logic [2:0] status_clr;
    logic [2:0] status_q;

    assign status_set = {events.buffer_error_set,
                         events.late_collision_set,
                         events.tx_aborted_set};
    assign status_clr = {status_clr_mask[EEF_ST_BUFFER_ERROR],
                         status_clr_mask[EEF_ST_LATE_COLLISION],
                         status_clr_mask[EEF_ST_TX_ABORTED]};

    eef_sticky #(
        .W (3)
    ) u_status_flags (
        .clk_sys (clk_sys),
        .reset   (reset),
        .set     (status_set),
        .clr     (status_clr),
        .q       (status_q)
    );

    // ==========
    // status read-only levels
    // ==========
    logic rx_active_ff;
    logic clock_ready_flag_ff;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rx_active_ff        <= 1'b0;
            clock_ready_flag_ff <= 1'b0;
        end else begin
            rx_active_ff        <= events.rx_active;
            clock_ready_flag_ff <= events.osc_startup_timer_done;
        end
    end

    // ==========
    // event flags: copy done, tx done, tx error, rx error
    // ==========
    // set regardless of any enable so the host can poll
    logic [3:0] ev_set;
    logic [3:0] ev_clr;
    logic [3:0] ev_q;

    assign ev_set = {events.copy_done_set,
                     events.tx_done_set,
                     events.tx_error_set,
                     events.rx_error_set};
    assign ev_clr = {flags_clr_mask[EEF_EV_COPY_DONE],
                     flags_clr_mask[EEF_EV_TX_DONE],
                     flags_clr_mask[EEF_EV_TX_ERROR],
                     flags_clr_mask[EEF_EV_RX_ERROR]};

    eef_sticky #(
        .W (4)
    ) u_event_flags (
        .clk_sys (clk_sys),
        .reset   (reset),
        .set     (ev_set),
        .clr     (ev_clr),
        .q       (ev_q)
    );

    // ==========
    // packet pending flag
    // ==========
    // follows the stored packet count; decrementing to zero clears it
    logic packet_pending_flag_ff;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            packet_pending_flag_ff <= 1'b0;
        end else begin
            packet_pending_flag_ff <= (events.packet_count != 8'h_00);
        end
    end

    // ==========
    // phy flags: link change and global, cleared by reading
    // ==========
    logic       phy_flags_read;
    logic [1:0] phy_set;
    logic [1:0] phy_clr;
    logic [1:0] phy_q;

    assign phy_flags_read = is_phy_flags & do_read;
    assign phy_set = {events.phy_link_change_set,
                      events.phy_link_change_set & phy_enable_ff[EEF_PHY_LINK_CHANGE]};
    assign phy_clr = {phy_flags_read, phy_flags_read};

    eef_sticky #(
        .W (2)
    ) u_phy_flags (
        .clk_sys (clk_sys),
        .reset   (reset),
        .set     (phy_set),
        .clr     (phy_clr),
        .q       (phy_q)
    );

    logic phy_link_change_flag;
    logic phy_global_flag;

    assign phy_link_change_flag = phy_q[1];
    assign phy_global_flag      = phy_q[0];

    // ==========
    // link change event flag
    // ==========
    // shadow of the phy global flag, never set unless both phy enables are on
    logic link_change_flag;

    assign link_change_flag = phy_global_flag & phy_both_enabled;

    // ==========
    // assembled flag and enable vectors
    // ==========
    logic [7:0] flags_value;
    logic [5:0] src_flags;
    logic [5:0] src_enables;

    always_comb begin
        flags_value                        = 8'h_00;
        flags_value[EEF_EV_PACKET_PENDING] = packet_pending_flag_ff;
        flags_value[EEF_EV_COPY_DONE]      = ev_q[3];
        flags_value[EEF_EV_LINK_CHANGE]    = link_change_flag;
        flags_value[EEF_EV_TX_DONE]        = ev_q[2];
        flags_value[EEF_EV_TX_ERROR]       = ev_q[1];
        flags_value[EEF_EV_RX_ERROR]       = ev_q[0];
    end

    assign src_flags   = {flags_value[EEF_EV_PACKET_PENDING:EEF_EV_TX_DONE],
                          flags_value[EEF_EV_TX_ERROR:EEF_EV_RX_ERROR]};
    assign src_enables = {enable_ff[EEF_EV_PACKET_PENDING:EEF_EV_TX_DONE],
                          enable_ff[EEF_EV_TX_ERROR:EEF_EV_RX_ERROR]};

    // ==========
    // interrupt output
    // ==========
    logic int_pending;
    logic int_n_stage;

    eef_int_stage #(
        .N (6)
    ) u_int_stage (
        .clk_sys       (clk_sys),
        .reset         (reset),
        .flags         (src_flags),
        .enables       (src_enables),
        .global_enable (enable_ff[EEF_EV_GLOBAL]),
        .pending       (int_pending),
        .int_n         (int_n_stage)
    );

    assign int_n = int_n_stage;

    // ==========
    // status value
    // ==========
    logic [7:0] status_value;

    always_comb begin
        status_value                        = 8'h_00;
        status_value[EEF_ST_PENDING]        = int_pending;
        status_value[EEF_ST_BUFFER_ERROR]   = status_q[2];
        status_value[EEF_ST_LATE_COLLISION] = status_q[1];
        status_value[EEF_ST_RX_ACTIVE]      = rx_active_ff;
        status_value[EEF_ST_TX_ABORTED]     = status_q[0];
        status_value[EEF_ST_CLOCK_READY]    = clock_ready_flag_ff;
    end

    // ==========
    // read mux
    // ==========
    logic [15:0] nxt_rdata;

    always_comb begin
        nxt_rdata = 16'h_0000;
        case (cmd.addr)
            EEF_IDX_STATUS: begin
                nxt_rdata = {8'h_00, status_value};
            end
            EEF_IDX_ENABLE: begin
                nxt_rdata = {8'h_00, enable_ff};
            end
            EEF_IDX_FLAGS: begin
                nxt_rdata = {8'h_00, flags_value};
            end
            EEF_IDX_PHY_ENABLE: begin
                nxt_rdata = phy_enable_ff;
            end
            EEF_IDX_PHY_FLAGS: begin
                nxt_rdata                      = 16'h_0000;
                nxt_rdata[EEF_PHY_LINK_CHANGE] = phy_link_change_flag;
                nxt_rdata[EEF_PHY_GLOBAL_FLAG] = phy_global_flag;
            end
            default: begin
                nxt_rdata = 16'h_0000;
            end
        endcase
    end

    // ==========
    // response register
    // ==========
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rsp <= '0;
        end else begin
            rsp.valid <= cmd.req;
            rsp.err   <= cmd.req & ~is_mapped;
            rsp.rdata <= (do_read & is_mapped) ? nxt_rdata : 16'h_0000;
        end
    end

endmodule : eef_top

// *** eef_pkg.sv ***
// event flag block package: register indices, field positions, reset values, carriers
// assumes one system clock; every user imports eef_pkg::*
package eef_pkg;

    // ==========================================================
    // register indices on the command port
    // ==========================================================
    localparam logic [2:0] EEF_IDX_STATUS     = 3'h0;
    localparam logic [2:0] EEF_IDX_ENABLE     = 3'h1;
    localparam logic [2:0] EEF_IDX_FLAGS      = 3'h2;
    localparam logic [2:0] EEF_IDX_PHY_ENABLE = 3'h3;
    localparam logic [2:0] EEF_IDX_PHY_FLAGS  = 3'h4;

    // ==========================================================
    // command opcodes
    // ==========================================================
    localparam logic [1:0] EEF_OP_READ  = 2'h0;
    localparam logic [1:0] EEF_OP_WRITE = 2'h1;
    localparam logic [1:0] EEF_OP_SET   = 2'h2;
    localparam logic [1:0] EEF_OP_CLEAR = 2'h3;

    // ==========================================================
    // controller status bit positions
    // ==========================================================
    localparam int EEF_ST_PENDING        = 7;
    localparam int EEF_ST_BUFFER_ERROR   = 6;
    localparam int EEF_ST_LATE_COLLISION = 4;
    localparam int EEF_ST_RX_ACTIVE      = 2;
    localparam int EEF_ST_TX_ABORTED     = 1;
    localparam int EEF_ST_CLOCK_READY    = 0;

    // ==========================================================
    // event enable / event flag bit positions
    // ==========================================================
    localparam int EEF_EV_GLOBAL         = 7;
    localparam int EEF_EV_PACKET_PENDING = 6;
    localparam int EEF_EV_COPY_DONE      = 5;
    localparam int EEF_EV_LINK_CHANGE    = 4;
    localparam int EEF_EV_TX_DONE        = 3;
    localparam int EEF_EV_TX_ERROR       = 1;
    localparam int EEF_EV_RX_ERROR       = 0;

    // writable enable bits: all but reserved bit 2
    localparam logic [7:0] EEF_ENABLE_WR_MASK = 8'h_fb;

    // ==========================================================
    // phy enable / phy flag bit positions
    // ==========================================================
    localparam int EEF_PHY_LINK_CHANGE = 4;
    localparam int EEF_PHY_GLOBAL_EN   = 1;
    localparam int EEF_PHY_GLOBAL_FLAG = 2;

    // ==========================================================
    // reset values
    // ==========================================================
    localparam logic [7:0]  EEF_ENABLE_RESET     = 8'h_00;
    localparam logic [15:0] EEF_PHY_ENABLE_RESET = 16'h_0000;

    // ==========================================================
    // carriers
    // ==========================================================
    typedef struct packed {
        logic        req;
        logic [1:0]  op;
        logic [2:0]  addr;
        logic [15:0] wdata;
    } eef_cmd_t;

    typedef struct packed {
        logic        valid;
        logic        err;
        logic [15:0] rdata;
    } eef_rsp_t;

    typedef struct packed {
        logic       buffer_error_set;
        logic       late_collision_set;
        logic       tx_aborted_set;
        logic       copy_done_set;
        logic       tx_done_set;
        logic       tx_error_set;
        logic       rx_error_set;
        logic       phy_link_change_set;
        logic       rx_active;
        logic       osc_startup_timer_done;
        logic [7:0] packet_count;
    } eef_events_t;

endpackage : eef_pkg

// *** eef_sticky.sv ***
// sticky flag vector: one flop per bit, set beats clear in the same cycle
// assumes set and clear are single-cycle strobes from the same clock domain
`timescale 1ns/1ps
module eef_sticky #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         reset,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] q
);

    // ==========
    // elaboration check
    // ==========
    generate
        if (W < 1) begin : g_bad_width
            $error("eef_sticky width must be at least one");
        end
    endgenerate

    // ==========
    // per-bit flag cells
    // ==========
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk_sys or posedge reset) begin
                if (reset) begin
                    q[i] <= 1'b0;
                end else if (set[i]) begin
                    q[i] <= 1'b1;
                end else if (clr[i]) begin
                    q[i] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule : eef_sticky

// *** eef_int_stage.sv ***
// interrupt output stage: combines flags and enables into a registered active-low line
// assumes flags and enables are registered values on clk_sys
`timescale 1ns/1ps
module eef_int_stage #(
    parameter int N = 6
) (
    input  wire logic         clk_sys,
    input  wire logic         reset,
    input  wire logic [N-1:0] flags,
    input  wire logic [N-1:0] enables,
    input  wire logic         global_enable,
    output logic              pending,
    output logic              int_n
);

    generate
        if (N < 1) begin : g_bad_count
            $error("eef_int_stage needs at least one source");
        end
    endgenerate

    logic nxt_pending;

    assign nxt_pending = |(flags & enables);

    // ==========
    // registered outputs, int_n high and pending low through reset
    // ==========
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pending <= 1'b0;
            int_n   <= 1'b1;
        end else begin
            pending <= nxt_pending;
            int_n   <= ~(nxt_pending & global_enable);
        end
    end

endmodule : eef_int_stage

// *** eef_sva.sv ***
// checker for eef_top: command answers, reserved bits, level mirrors, interrupt gating
// assumes binding to eef_top with clk_sys and active-high async reset
`timescale 1ns/1ps
module eef_sva
    import eef_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire eef_cmd_t    cmd,
    input wire eef_events_t events,
    input wire eef_rsp_t    rsp,
    input wire logic        int_n
);
    // ==========
    // shadow of the enable register and of the last command
    logic [7:0] en_ff;
    logic       rop_ff;
    logic [2:0] ad_ff;
    logic       rd_st, rd_fl, rd_pe;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) en_ff <= 8'h_00;
        else if (cmd.req && cmd.addr == EEF_IDX_ENABLE)
            en_ff <= (cmd.op == EEF_OP_WRITE) ? cmd.wdata[7:0] & EEF_ENABLE_WR_MASK :
                     (cmd.op == EEF_OP_SET) ? en_ff | (cmd.wdata[7:0] & EEF_ENABLE_WR_MASK) :
                     (cmd.op == EEF_OP_CLEAR) ? en_ff & ~cmd.wdata[7:0] : en_ff;
    end
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) {rop_ff, ad_ff} <= 4'h_0;
        else {rop_ff, ad_ff} <= {cmd.op == EEF_OP_READ, cmd.addr};
    end
    assign rd_st = rsp.valid && rop_ff && ad_ff == EEF_IDX_STATUS;
    assign rd_fl = rsp.valid && rop_ff && ad_ff == EEF_IDX_FLAGS;
    assign rd_pe = rsp.valid && rop_ff && ad_ff == EEF_IDX_PHY_ENABLE;
    // ==========
    // properties
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    rsp_answer_a: assert property (cmd.req |=> rsp.valid) else $error("no answer after command");
    rsp_quiet_a: assert property (!cmd.req |=> !rsp.valid) else $error("answer without command");
    unmapped_err_a: assert property (cmd.req && cmd.addr > 3'h4 |=> rsp.err && rsp.rdata == 16'h_0000)
        else $error("unmapped index not refused");
    global_off_a: assert property (!en_ff[EEF_EV_GLOBAL] |=> int_n) else $error("int low with global off");
    int_gate_a: assert property (!int_n |-> $past(en_ff[EEF_EV_GLOBAL])) else $error("int low ungated");
    status_rsvd_a: assert property (rd_st |-> rsp.rdata[5] == 1'b0 && rsp.rdata[3] == 1'b0) else $error("status rsvd");
    flags_rsvd_a: assert property (rd_fl |-> !rsp.rdata[7] && !rsp.rdata[2]) else $error("flags rsvd set");
    rx_active_a: assert property (rd_st |-> rsp.rdata[EEF_ST_RX_ACTIVE] == $past(events.rx_active, 2))
        else $error("receive busy bit wrong");
    clock_ready_a: assert property (rd_st |-> rsp.rdata[0] == $past(events.osc_startup_timer_done, 2))
        else $error("clock ready bit wrong");
    pkt_pending_a: assert property (rd_fl |-> rsp.rdata[6] == ($past(events.packet_count, 2) != 8'h_00))
        else $error("packet pending bit wrong");
    phy_en_rsvd_a: assert property (rd_pe |-> (rsp.rdata & 16'h_ffed) == 16'h_0000) else $error("phy en rsvd");
    cover property (rd_st && rsp.rdata[EEF_ST_PENDING]);
    cover property ($fell(int_n));
    cover property (rd_fl && rsp.rdata[EEF_EV_LINK_CHANGE]);
endmodule : eef_sva

bind eef_top eef_sva chk (.clk_sys(clk_sys), .reset(reset), .cmd(cmd), .events(events), .rsp(rsp), .int_n(int_n));

// *** eef_host.sv ***
// host model: issues one command at a time on the command port and takes the answer
// assumes the answer stands for the one cycle after the taking edge
`timescale 1ns/1ps
module eef_host
    import eef_pkg::*;
(
    input  wire logic     clk_sys,
    output eef_cmd_t      cmd,
    input  wire eef_rsp_t rsp
);
    initial cmd = '0;
    // ==========
    // one command, answer sampled once settled after the taking edge
    task automatic xfer(input logic [1:0] op, input logic [2:0] a, input logic [15:0] wd, output eef_rsp_t r);
        @(posedge clk_sys);
        cmd <= '{req: 1'b1, op: op, addr: a, wdata: wd};
        @(posedge clk_sys);
        cmd <= '0;
        #1;
        r = rsp;
    endtask : xfer
endmodule : eef_host

// *** ethernet_event_flags_tb.sv ***
// testbench for eef_top: host model, event driver and a reference model checked at every read
// assumes eef_pkg, eef_top, eef_host and eef_sva are compiled first
`timescale 1ns/1ps
module ethernet_event_flags_tb
    import eef_pkg::*;
;
    logic        clk_sys, reset, int_n;
    logic [17:0] ev_bits;
    eef_events_t ev;
    eef_cmd_t    cmd;
    eef_rsp_t    rsp, r;
    int          n_errors, num_checks, cycles, seed;
    logic [15:0] m_st, m_fl, m_en, m_pe, m_pf;
    assign ev = ev_bits;
    eef_top dut (.clk_sys(clk_sys), .reset(reset), .cmd(cmd), .events(ev), .rsp(rsp), .int_n(int_n));
    eef_host host (.clk_sys(clk_sys), .cmd(cmd), .rsp(rsp));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // ==========
    // reference model
    function automatic logic [15:0] exp_rd(input logic [2:0] a);
        logic [7:0] fl;
        fl = m_fl[7:0] | {1'b0, ev_bits[7:0] != 8'h_00, 1'b0, m_pf[2] & m_pe[4] & m_pe[1], 4'h_0};
        case (a)
            EEF_IDX_STATUS: return {8'h_00, |(fl & m_en[7:0] & 8'h_7b), m_st[6:0] | {4'h_0, ev_bits[9], 1'b0, ev_bits[8]}};
            EEF_IDX_ENABLE: return m_en;
            EEF_IDX_FLAGS: return {8'h_00, fl};
            EEF_IDX_PHY_ENABLE: return m_pe;
            EEF_IDX_PHY_FLAGS: return m_pf;
            default: return 16'h_0000;
        endcase
    endfunction : exp_rd
    function automatic logic [15:0] nv(input logic [15:0] o, input logic [1:0] op, input logic [15:0] d,
                                       input logic [15:0] m, input logic rw);
        case (op)
            EEF_OP_WRITE: return rw ? d & m : o & d;
            EEF_OP_SET: return rw ? o | (d & m) : o;
            EEF_OP_CLEAR: return o & ~d;
            default: return o;
        endcase
    endfunction : nv
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic rd(input logic [2:0] a);
        logic [15:0] e;
        e = exp_rd(a);
        host.xfer(EEF_OP_READ, a, 16'h_0000, r);
        chk({14'h_0, r.valid, r.err}, {14'h_0, 1'b1, a > 3'h4});
        chk(r.rdata, e);
        if (a == EEF_IDX_PHY_FLAGS) m_pf = 16'h_0000;
    endtask : rd
    task automatic wr(input logic [1:0] op, input logic [2:0] a, input logic [15:0] d);
        host.xfer(op, a, d, r);
        case (a)
            EEF_IDX_STATUS: m_st = nv(m_st, op, d, 16'h_0000, 1'b0);
            EEF_IDX_ENABLE: m_en = nv(m_en, op, d, 16'h_00fb, 1'b1);
            EEF_IDX_FLAGS: m_fl = nv(m_fl, op, d, 16'h_0000, 1'b0);
            EEF_IDX_PHY_ENABLE: m_pe = nv(m_pe, op, d, 16'h_0012, 1'b1);
            default: ;
        endcase
    endtask : wr
    // k 7..0: buffer error, late collision, abort, copy, tx done, tx error, rx error, phy link
    task automatic pulse(input int k);
        @(posedge clk_sys);
        ev_bits[10+k] <= 1'b1;
        @(posedge clk_sys);
        ev_bits[17:10] <= 8'h_00;
        case (k)
            7: m_st[6] = 1'b1;
            6: m_st[4] = 1'b1;
            5: m_st[1] = 1'b1;
            4: m_fl[5] = 1'b1;
            3: m_fl[3] = 1'b1;
            2: m_fl[1] = 1'b1;
            1: m_fl[0] = 1'b1;
            default: m_pf = m_pf | {11'h_0, 1'b1, 1'b0, m_pe[4], 2'h_0};
        endcase
    endtask : pulse
    task automatic chk_int();
        logic [15:0] e;
        repeat (3) @(posedge clk_sys);
        #1 e = exp_rd(EEF_IDX_STATUS);
        chk({15'h_0, int_n}, {15'h_0, ~(e[7] & m_en[7])});
    endtask : chk_int
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            test_done();
        end
    end
    // ==========
    // main sequence
    initial begin
        {reset, ev_bits, cycles, n_errors, num_checks, seed} = {1'b1, 18'h_0, 96'h_0, 32'h_1cba};
        {m_st, m_fl, m_en, m_pe, m_pf} = '0;
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        for (int a = 0; a < 8; a++) rd(3'(a));
        $display("reset and unmapped test done");
        repeat (2) for (int op = 1; op < 4; op++) begin
            wr(2'(op), EEF_IDX_ENABLE, 16'($random(seed)) & 16'h_007b);
            rd(EEF_IDX_ENABLE);
            wr(2'(op), EEF_IDX_PHY_ENABLE, 16'($random(seed)) & 16'h_0012);
            rd(EEF_IDX_PHY_ENABLE);
        end
        $display("enable test done");
        wr(EEF_OP_WRITE, EEF_IDX_ENABLE, 16'h_007b);
        wr(EEF_OP_WRITE, EEF_IDX_PHY_ENABLE, 16'h_0012);
        for (int k = 0; k < 8; k++) pulse(k);
        chk_int();
        for (int a = 0; a < 5; a++) rd(3'(a));
        rd(EEF_IDX_FLAGS);
        wr(EEF_OP_SET, EEF_IDX_FLAGS, 16'h_00ff);
        wr(EEF_OP_WRITE, EEF_IDX_FLAGS, 16'h_00fd);
        rd(EEF_IDX_FLAGS);
        $display("event flag test done");
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            ev_bits[9:0] <= (i == 0) ? 10'h_000 : 10'($random(seed));
            repeat (2) @(posedge clk_sys);
            rd(EEF_IDX_STATUS);
            rd(EEF_IDX_FLAGS);
        end
        $display("level test done");
        wr(EEF_OP_SET, EEF_IDX_ENABLE, 16'h_0080);
        chk_int();
        wr(EEF_OP_CLEAR, EEF_IDX_FLAGS, 16'h_00ff);
        wr(EEF_OP_CLEAR, EEF_IDX_STATUS, 16'h_0052);
        @(posedge clk_sys);
        ev_bits[7:0] <= 8'h_00;
        chk_int();
        rd(EEF_IDX_STATUS);
        pulse(3);
        chk_int();
        wr(EEF_OP_CLEAR, EEF_IDX_ENABLE, 16'h_0008);
        chk_int();
        $display("interrupt test done");
        test_done();
    end
endmodule : ethernet_event_flags_tb
